// ==== src/dml_link_control.sv ====
// Dial-up modem link controller: control lines, command strings, connect timer
//
// What this block does
// - DTR falling makes modem drop call
// - Send line-behaviour setup string, then store
// - Every command ends with CR, LF
// - Command strings go out raw, unframed
// - Dial trigger sends tone prefix plus digits
// - Length zero sends the whole string
// - Dialing starts connect timer, watch lost-modem
// - Lost-modem falls when connection is made
// - Timer expiry: hang up, retry later
// - Connected link carries traffic both ways
// - Channel must be full-duplex before dialing
// - Hang up: DTR low, then high again
`timescale 1ns/1ns
`include "dml_defs.svh"

module dml_link_control #(
    parameter int BAUD_DIV = `DML_BAUD_DIV,
    parameter int HANGUP_CYCLES = `DML_HANGUP_CYCLES,
    parameter int RETRY_CYCLES = `DML_RETRY_CYCLES,
    parameter int DIGITS_MAX = `DML_DIGITS_MAX
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic dsr_i,
    input wire logic cd_i,
    input wire logic rxd_i,
    output logic dtr_o,
    output logic txd_o,
    input wire logic chan_fdx_i,
    input wire logic cfg_req_i,
    input wire logic dial_req_i,
    input wire logic hangup_req_i,
    input wire logic retry_en_i,
    input wire logic [7:0] dial_len_i,
    input wire logic [31:0] conn_timeout_i,
    input wire logic digit_clear_i,
    input wire logic digit_push_i,
    input wire logic [7:0] digit_data_i,
    input wire dml_pkg::dml_byte_type tx_in_i,
    output logic tx_ready_o,
    output dml_pkg::dml_byte_type rx_out_o,
    output logic lost_modem_o,
    output logic connected_o,
    output logic busy_o,
    output logic dial_fail_o
);

    // ****************************************************************
    // State and storage
    // ****************************************************************
    dml_pkg::dml_ctrl_type r;
    dml_pkg::dml_ctrl_type next_r;
    logic [7:0] digit_mem [DIGITS_MAX];

    logic lost;
    logic dial_rise;
    logic sending;
    logic [7:0] whole_len;
    logic [7:0] body_len;
    logic [7:0] body_char;
    logic [7:0] send_char;
    logic uart_ready;
    dml_pkg::dml_byte_type uart_in;
    dml_pkg::dml_byte_type uart_out;

    // ****************************************************************
    // Fixed strings
    // ****************************************************************
    // control-line setup
    function automatic logic [7:0] cfg_char(input logic [7:0] i);
        case (i)
            8'h00: cfg_char = 8'h41;
            8'h01: cfg_char = 8'h54;
            8'h02: cfg_char = 8'h20;
            8'h03: cfg_char = 8'h26;
            8'h04: cfg_char = 8'h53;
            8'h05: cfg_char = 8'h31;
            8'h06: cfg_char = 8'h20;
            8'h07: cfg_char = 8'h26;
            8'h08: cfg_char = 8'h43;
            8'h09: cfg_char = 8'h31;
            8'h0A: cfg_char = 8'h20;
            8'h0B: cfg_char = 8'h26;
            8'h0C: cfg_char = 8'h44;
            8'h0D: cfg_char = 8'h32;
            8'h0E: cfg_char = 8'h20;
            8'h0F: cfg_char = 8'h51;
            8'h10: cfg_char = 8'h31;
            8'h11: cfg_char = 8'h20;
            8'h12: cfg_char = 8'h45;
            8'h13: cfg_char = 8'h20;
            8'h14: cfg_char = 8'h26;
            8'h15: cfg_char = 8'h57;
            default: cfg_char = 8'h20;
        endcase
    endfunction

    function automatic logic [7:0] prefix_char(input logic [1:0] i);
        case (i)
            2'h0: prefix_char = 8'h61;
            2'h1: prefix_char = 8'h74;
            2'h2: prefix_char = 8'h64;
            default: prefix_char = 8'h74;
        endcase
    endfunction

    // ****************************************************************
    // Line status and string selection
    // ****************************************************************
    // lost-modem clears once both DSR and CD are seen
    assign lost = !(r.dsr_s2 && r.cd_s2);
    assign dial_rise = dial_req_i && !r.dial_prev;
    assign sending = (r.state == dml_pkg::DML_CFG) || (r.state == dml_pkg::DML_DIAL);
    assign whole_len = `DML_PREFIX_LEN + {2'h0, r.count};

    // zero or oversize length means the whole string
    always_comb begin
        if (r.state == dml_pkg::DML_CFG) begin
            body_len = `DML_CFG_LEN;
        end else if (dial_len_i == 8'h00 || dial_len_i > whole_len) begin
            body_len = whole_len;
        end else begin
            body_len = dial_len_i;
        end
    end

    always_comb begin
        if (r.state == dml_pkg::DML_CFG) begin
            body_char = cfg_char(r.idx);
        end else if (r.idx < `DML_PREFIX_LEN) begin
            body_char = prefix_char(r.idx[1:0]);
        end else begin
            body_char = digit_mem[5'(r.idx - `DML_PREFIX_LEN)];
        end
    end

    // CR then LF after the body
    always_comb begin
        if (r.idx < body_len) begin
            send_char = body_char;
        end else if (r.idx == body_len) begin
            send_char = `DML_CR;
        end else begin
            send_char = `DML_LF;
        end
    end

    // ****************************************************************
    // Transmit path
    // ****************************************************************
    // command bytes bypass the framed traffic path
    always_comb begin
        if (sending) begin
            uart_in = '{valid: 1'b1, data: send_char};
        end else if (r.state == dml_pkg::DML_CONN) begin
            uart_in = tx_in_i;
        end else begin
            uart_in = '{valid: 1'b0, data: 8'h00};
        end
    end

    assign tx_ready_o = (r.state == dml_pkg::DML_CONN) && uart_ready;

    // ****************************************************************
    // Control sequence
    // ****************************************************************
    always_comb begin
        next_r = r;
        next_r.dsr_s1 = dsr_i;
        next_r.dsr_s2 = r.dsr_s1;
        next_r.cd_s1 = cd_i;
        next_r.cd_s2 = r.cd_s1;
        next_r.dial_prev = dial_req_i;
        next_r.fail = 1'b0;
        if (digit_clear_i) begin
            next_r.count = 6'h00;
        end else if (digit_push_i && r.count < 6'(DIGITS_MAX) && !sending) begin
            next_r.count = r.count + 6'h01;
        end
        case (r.state)
            dml_pkg::DML_IDLE: begin
                // DTR held high so calls can be accepted
                next_r.dtr = 1'b1;
                next_r.idx = 8'h00;
                if (!lost) begin
                    next_r.state = dml_pkg::DML_CONN;
                end else if (chan_fdx_i && dial_rise) begin
                    next_r.state = dml_pkg::DML_DIAL;
                end else if (chan_fdx_i && cfg_req_i) begin
                    next_r.state = dml_pkg::DML_CFG;
                end
            end
            dml_pkg::DML_CFG, dml_pkg::DML_DIAL: begin
                if (uart_ready) begin
                    next_r.idx = r.idx + 8'h01;
                    if (r.idx == body_len + 8'h01) begin
                        next_r.idx = 8'h00;
                        if (r.state == dml_pkg::DML_CFG) begin
                            next_r.state = dml_pkg::DML_IDLE;
                        end else begin
                            // connect timer starts after the dial command
                            next_r.state = dml_pkg::DML_WAIT;
                            next_r.timer = conn_timeout_i;
                        end
                    end
                end
            end
            dml_pkg::DML_WAIT: begin
                if (!lost) begin
                    next_r.state = dml_pkg::DML_CONN;
                    next_r.retry_pend = 1'b0;
                end else if (r.timer == 32'h0) begin
                    // no answer in time: hang up, retry later
                    next_r.state = dml_pkg::DML_HANG_LOW;
                    next_r.timer = 32'(HANGUP_CYCLES - 1);
                    next_r.dtr = 1'b0;
                    next_r.fail = 1'b1;
                    next_r.retry_pend = retry_en_i;
                end else begin
                    next_r.timer = r.timer - 32'h1;
                end
            end
            dml_pkg::DML_CONN: begin
                if (hangup_req_i) begin
                    next_r.state = dml_pkg::DML_HANG_LOW;
                    next_r.timer = 32'(HANGUP_CYCLES - 1);
                    next_r.dtr = 1'b0;
                    next_r.retry_pend = 1'b0;
                end else if (lost) begin
                    next_r.state = dml_pkg::DML_IDLE;
                end
            end
            dml_pkg::DML_HANG_LOW: begin
                if (r.timer == 32'h0) begin
                    // DTR back high ends the pulse
                    next_r.state = dml_pkg::DML_HANG_HIGH;
                    next_r.dtr = 1'b1;
                    next_r.timer = r.retry_pend ? 32'(RETRY_CYCLES - 1) : 32'h0;
                end else begin
                    next_r.timer = r.timer - 32'h1;
                end
            end
            dml_pkg::DML_HANG_HIGH: begin
                if (r.timer == 32'h0) begin
                    next_r.idx = 8'h00;
                    if (r.retry_pend && chan_fdx_i) begin
                        next_r.state = dml_pkg::DML_DIAL;
                    end else begin
                        next_r.state = dml_pkg::DML_IDLE;
                    end
                    next_r.retry_pend = 1'b0;
                end else begin
                    next_r.timer = r.timer - 32'h1;
                end
            end
            default: begin
                next_r.state = dml_pkg::DML_IDLE;
                next_r.dtr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r <= '{state: dml_pkg::DML_IDLE, idx: 8'h00, timer: 32'h0,
                   dtr: `DML_DTR_RESET, dial_prev: 1'b1, retry_pend: 1'b0,
                   fail: 1'b0, count: 6'h00, dsr_s1: 1'b0, dsr_s2: 1'b0,
                   cd_s1: 1'b0, cd_s2: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // Digit store: appends one digit per push
    always_ff @(posedge mclk_i) begin
        if (digit_push_i && !digit_clear_i && r.count < 6'(DIGITS_MAX) && !sending) begin
            digit_mem[r.count[4:0]] <= digit_data_i;
        end
    end

    // ****************************************************************
    // Serial channel
    // ****************************************************************
    dml_uart_tx #(
        .BAUD_DIV(BAUD_DIV)
    ) u_tx (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .in_i(uart_in),
        .ready_o(uart_ready),
        .txd_o(txd_o)
    );

    dml_uart_rx #(
        .BAUD_DIV(BAUD_DIV)
    ) u_rx (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .rxd_i(rxd_i),
        .out_o(uart_out)
    );

    // received bytes pass up only while connected
    assign rx_out_o = '{valid: uart_out.valid && (r.state == dml_pkg::DML_CONN), data: uart_out.data};

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // DTR from a flip-flop
    assign dtr_o = r.dtr;
    assign lost_modem_o = lost;
    assign connected_o = (r.state == dml_pkg::DML_CONN);
    assign busy_o = (r.state != dml_pkg::DML_IDLE) && (r.state != dml_pkg::DML_CONN);
    assign dial_fail_o = r.fail;

endmodule // dml_link_control

// ==== shared/dml_defs.svh ====
// Constants of the dial-up modem link controller
`ifndef DML_DEFS_SVH
`define DML_DEFS_SVH

// ****************************************************************
// Clock and serial timing
// ****************************************************************
`define DML_MCLK_HZ 250000000
`define DML_BAUD 9600
`define DML_BAUD_DIV (`DML_MCLK_HZ / `DML_BAUD)

// ****************************************************************
// Line control timing
// ****************************************************************
`define DML_HANGUP_MS 500
`define DML_HANGUP_CYCLES (`DML_HANGUP_MS * (`DML_MCLK_HZ / 1000))
`define DML_RETRY_MS 2000
`define DML_RETRY_CYCLES (`DML_RETRY_MS * (`DML_MCLK_HZ / 1000))

// ****************************************************************
// Command strings
// ****************************************************************
`define DML_CFG_LEN 8'h16
`define DML_PREFIX_LEN 8'h04
`define DML_DIGITS_MAX 32
`define DML_CR 8'h0D
`define DML_LF 8'h0A

// ****************************************************************
// Reset values
// ****************************************************************
`define DML_DTR_RESET 1'b1
`define DML_TXD_IDLE 10'h3FF

`endif

// ==== shared/dml_pkg.sv ====
// Types of the dial-up modem link controller
package dml_pkg;

    typedef enum logic [2:0] {
        DML_IDLE = 3'b000,
        DML_CFG = 3'b001,
        DML_DIAL = 3'b010,
        DML_WAIT = 3'b011,
        DML_CONN = 3'b100,
        DML_HANG_LOW = 3'b101,
        DML_HANG_HIGH = 3'b110
    } dml_state_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } dml_byte_type;

    typedef struct packed {
        logic busy;
        logic [9:0] shift;
        logic [3:0] nbits;
        logic [31:0] cnt;
    } dml_tx_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic busy;
        logic [3:0] nbits;
        logic [31:0] cnt;
        logic [7:0] shift;
        logic valid;
        logic [7:0] data;
    } dml_rx_type;

    typedef struct packed {
        dml_state_type state;
        logic [7:0] idx;
        logic [31:0] timer;
        logic dtr;
        logic dial_prev;
        logic retry_pend;
        logic fail;
        logic [5:0] count;
        logic dsr_s1;
        logic dsr_s2;
        logic cd_s1;
        logic cd_s2;
    } dml_ctrl_type;

endpackage

// ==== src/dml_uart_tx.sv ====
// Serial transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
`include "dml_defs.svh"

module dml_uart_tx #(
    parameter int BAUD_DIV = `DML_BAUD_DIV
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire dml_pkg::dml_byte_type in_i,
    output logic ready_o,
    output logic txd_o
);

    dml_pkg::dml_tx_type r;
    dml_pkg::dml_tx_type next_r;

    always_comb begin
        next_r = r;
        if (!r.busy) begin
            if (in_i.valid) begin
                next_r.busy = 1'b1;
                next_r.shift = {1'b1, in_i.data, 1'b0};
                next_r.nbits = 4'hA;
                next_r.cnt = 32'(BAUD_DIV - 1);
            end
        end else if (r.cnt == 32'h0) begin
            next_r.shift = {1'b1, r.shift[9:1]};
            next_r.nbits = r.nbits - 4'h1;
            next_r.cnt = 32'(BAUD_DIV - 1);
            if (r.nbits == 4'h1) begin
                next_r.busy = 1'b0;
            end
        end else begin
            next_r.cnt = r.cnt - 32'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r <= '{busy: 1'b0, shift: `DML_TXD_IDLE, nbits: 4'h0, cnt: 32'h0};
        end else begin
            r <= next_r;
        end
    end

    assign ready_o = !r.busy;
    assign txd_o = r.shift[0];

endmodule // dml_uart_tx

// ==== src/dml_uart_rx.sv ====
// Serial receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
`include "dml_defs.svh"

module dml_uart_rx #(
    parameter int BAUD_DIV = `DML_BAUD_DIV
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic rxd_i,
    output dml_pkg::dml_byte_type out_o
);

    dml_pkg::dml_rx_type r;
    dml_pkg::dml_rx_type next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = rxd_i;
        next_r.s2 = r.s1;
        next_r.valid = 1'b0;
        if (!r.busy) begin
            // Start edge, first sample in the middle of bit 0
            if (!r.s2) begin
                next_r.busy = 1'b1;
                next_r.nbits = 4'h9;
                next_r.cnt = 32'(BAUD_DIV + BAUD_DIV / 2 - 1);
            end
        end else if (r.cnt == 32'h0) begin
            next_r.nbits = r.nbits - 4'h1;
            next_r.cnt = 32'(BAUD_DIV - 1);
            if (r.nbits == 4'h1) begin
                // Stop bit: deliver only a well framed byte
                next_r.busy = 1'b0;
                next_r.valid = r.s2;
                next_r.data = r.shift;
            end else begin
                next_r.shift = {r.s2, r.shift[7:1]};
            end
        end else begin
            next_r.cnt = r.cnt - 32'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            r <= '{s1: 1'b1, s2: 1'b1, busy: 1'b0, nbits: 4'h0, cnt: 32'h0,
                   shift: 8'h00, valid: 1'b0, data: 8'h00};
        end else begin
            r <= next_r;
        end
    end

    assign out_o = '{valid: r.valid, data: r.data};

endmodule // dml_uart_rx

// ==== verif/dml_modem_model.sv ====
// Behavioural dial-up modem facing the link controller
`timescale 1ns/1ns
module dml_modem_model #(
    parameter int BAUD_DIV = 8
) (
    input wire logic mclk_i,
    input wire logic dtr_i,
    input wire logic txd_i,
    input wire logic answer_i,
    input wire logic send_i,
    input wire logic [7:0] send_data_i,
    output logic dsr_o,
    output logic cd_o,
    output logic rxd_o,
    output logic got_o,
    output logic [7:0] got_data_o
);
    logic online;
    logic [7:0] sh;
    event ring;
    assign dsr_o = online;
    assign cd_o = online;
    // Drop the call on DTR fall or far-end hang-up
    initial begin
        online = 1'b0;
        forever begin
            @(negedge dtr_i or negedge answer_i or ring);
            online = dtr_i && answer_i;
        end
    end
    initial begin
        got_o = 1'b0;
        got_data_o = 8'h00;
        forever begin
            @(negedge txd_i);
            repeat (BAUD_DIV / 2) @(posedge mclk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BAUD_DIV) @(posedge mclk_i);
                sh[i] = txd_i;
            end
            repeat (BAUD_DIV) @(posedge mclk_i);
            @(negedge mclk_i);
            got_data_o = sh;
            got_o = 1'b1;
            @(negedge mclk_i);
            got_o = 1'b0;
            if (sh == 8'h0A && answer_i && dtr_i) begin
                repeat (10) @(negedge mclk_i);
                -> ring;
            end
        end
    end
    // No echo or result codes, only peer data
    initial begin
        rxd_o = 1'b1;
        forever begin
            @(posedge send_i);
            rxd_o = 1'b0;
            repeat (BAUD_DIV) @(negedge mclk_i);
            for (int i = 0; i < 8; i++) begin
                rxd_o = send_data_i[i];
                repeat (BAUD_DIV) @(negedge mclk_i);
            end
            rxd_o = 1'b1;
        end
    end
endmodule // dml_modem_model

// ==== verif/dml_link_control_chk.sv ====
// Port assertions for the modem link controller
`timescale 1ns/1ns
module dml_link_control_chk #(
    parameter int HANGUP_CYCLES = 20
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic dsr_i,
    input wire logic cd_i,
    input wire logic chan_fdx_i,
    input wire logic dtr_o,
    input wire logic txd_o,
    input wire logic tx_ready_o,
    input wire dml_pkg::dml_byte_type rx_out_o,
    input wire logic lost_modem_o,
    input wire logic connected_o,
    input wire logic busy_o,
    input wire logic dial_fail_o
);
    // ****************************************************************
    // Helper count of DTR low cycles
    // ****************************************************************
    logic [31:0] low_cnt;
    always_ff @(posedge mclk_i) begin
        if (reset_i || dtr_o) begin
            low_cnt <= 32'h0;
        end else begin
            low_cnt <= low_cnt + 32'h1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    a_lost_clears: assert property ((dsr_i && cd_i) [*5] |-> !lost_modem_o)
        else $error("lost modem bit stays set on a live call");
    a_lost_sets: assert property ((!cd_i) [*5] |-> lost_modem_o)
        else $error("lost modem bit clear without carrier");
    a_hang_length: assert property ($rose(dtr_o) |-> low_cnt == 32'(HANGUP_CYCLES))
        else $error("hang-up pulse has wrong length");
    a_dtr_held: assert property (!dtr_o |-> busy_o && !connected_o)
        else $error("DTR low outside hang-up");
    a_fail_hangs: assert property (dial_fail_o |-> !dtr_o && !connected_o)
        else $error("timeout without hang-up");
    a_fdx_gate: assert property ($rose(busy_o) && !$past(connected_o) |-> $past(chan_fdx_i))
        else $error("request taken without full duplex");
    a_first_start: assert property ($rose(busy_o) && !$past(connected_o) |-> ##[1:4] !txd_o)
        else $error("command string did not start");
    a_ready_conn: assert property (tx_ready_o |-> connected_o)
        else $error("peer transmit ready while not connected");
    a_rx_conn: assert property (rx_out_o.valid |-> connected_o)
        else $error("peer byte delivered while not connected");
    a_conn_drop: assert property (connected_o && lost_modem_o |=> !connected_o)
        else $error("connection kept after loss");
endmodule // dml_link_control_chk
bind dml_link_control dml_link_control_chk #(.HANGUP_CYCLES(HANGUP_CYCLES)) dml_link_control_chk_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .dsr_i(dsr_i), .cd_i(cd_i), .chan_fdx_i(chan_fdx_i), .dtr_o(dtr_o),
    .txd_o(txd_o), .tx_ready_o(tx_ready_o), .rx_out_o(rx_out_o), .lost_modem_o(lost_modem_o),
    .connected_o(connected_o), .busy_o(busy_o), .dial_fail_o(dial_fail_o));

// ==== verif/tb.sv ====
// Self-checking bench for the modem link controller
`timescale 1ns/1ns
module tb;
    localparam int BD = 8;
    localparam int BUSY = 0;
    localparam int CONN = 1;
    localparam int FAIL = 2;
    localparam int RDY = 3;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic dsr, cd, rxd, dtr, txd, fdx, cfg_req, dial_req, hang_req, retry_en, dclr, dpush;
    logic [7:0] dial_len, ddata, send_data, got_data;
    logic [31:0] timeout;
    dml_pkg::dml_byte_type tx_in, rx_out;
    logic tx_ready, lost, conn, busy, fail, answer, send, got;
    logic [3:0] st;
    logic [7:0] exp_tx[$];
    logic [7:0] exp_rx[$];
    string num;
    int miscompares = 0;
    int total_checks = 0;
    assign st = {tx_ready, fail, conn, busy};
    always #2 mclk_i = ~mclk_i;
    dml_link_control #(.BAUD_DIV(BD), .HANGUP_CYCLES(20), .RETRY_CYCLES(30), .DIGITS_MAX(32)) dml_link_control_i (
        .mclk_i(mclk_i), .reset_i(reset_i), .dsr_i(dsr), .cd_i(cd), .rxd_i(rxd), .dtr_o(dtr), .txd_o(txd),
        .chan_fdx_i(fdx), .cfg_req_i(cfg_req), .dial_req_i(dial_req), .hangup_req_i(hang_req),
        .retry_en_i(retry_en), .dial_len_i(dial_len), .conn_timeout_i(timeout), .digit_clear_i(dclr),
        .digit_push_i(dpush), .digit_data_i(ddata), .tx_in_i(tx_in), .tx_ready_o(tx_ready), .rx_out_o(rx_out),
        .lost_modem_o(lost), .connected_o(conn), .busy_o(busy), .dial_fail_o(fail));
    dml_modem_model #(.BAUD_DIV(BD)) dml_modem_model_i (.mclk_i(mclk_i), .dtr_i(dtr), .txd_i(txd),
        .answer_i(answer), .send_i(send), .send_data_i(send_data), .dsr_o(dsr), .cd_o(cd), .rxd_o(rxd),
        .got_o(got), .got_data_o(got_data));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (exp !== seen) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cycles(1);
        s = 1'b0;
        cycles(1);
    endtask
    task automatic wait_for(input int sel, input logic v, input int limit);
        for (int k = 0; k < limit && st[sel] !== v; k++) begin
            cycles(1);
        end
    endtask
    task automatic expect_str(input string s);
        for (int i = 0; i < s.len(); i++) begin
            exp_tx.push_back(s[i]);
        end
        exp_tx.push_back(8'h0D);
        exp_tx.push_back(8'h0A);
    endtask
    task automatic hang_up();
        hang_req = 1'b1;
        cycles(2);
        hang_req = 1'b0;
        wait_for(BUSY, 1'b0, 200);
        check("dtr after hang", 1, dtr);
        check("lost after hang", 1, lost);
        check("conn after hang", 0, conn);
    endtask
    always @(posedge mclk_i) begin
        if (got === 1'b1) begin
            check("modem char", exp_tx.size() > 0 ? exp_tx.pop_front() : 8'hXX, got_data);
        end
    end
    always @(negedge mclk_i) begin
        if (rx_out.valid === 1'b1) begin
            check("peer rx", exp_rx.size() > 0 ? exp_rx.pop_front() : 8'hXX, rx_out.data);
        end
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {fdx, cfg_req, dial_req, hang_req, retry_en, dclr, dpush, answer, send} = 9'h000;
        {dial_len, ddata, send_data, timeout, tx_in} = 65'h0;
        num = "";
        void'($urandom(82452));
        cycles(2);
        check("dtr at reset", 1, dtr);
        check("lost at reset", 1, lost);
        reset_i = 1'b0;
        cycles(1);
        $display("test reset done");
        dial_req = 1'b1;
        cfg_req = 1'b1;
        cycles(3);
        check("busy without duplex", 0, busy);
        {dial_req, cfg_req} = 2'h0;
        fdx = 1'b1;
        cycles(1);
        check("idle with duplex", 0, busy);
        $display("test refusal done");
        expect_str("AT &S1 &C1 &D2 Q1 E &W");
        pulse(cfg_req);
        wait_for(BUSY, 1'b0, 4000);
        cycles(BD * 12);
        check("setup chars left", 0, exp_tx.size());
        $display("test setup string done");
        pulse(dclr);
        for (int i = 0; i < 7; i++) begin
            ddata = 8'h30 + 8'($urandom_range(9));
            num = {num, string'(ddata)};
            pulse(dpush);
        end
        answer = 1'b1;
        timeout = 32'h7D0;
        expect_str({"atdt", num});
        pulse(dial_req);
        wait_for(CONN, 1'b1, 3000);
        check("connected", 1, conn);
        check("lost cleared", 0, lost);
        tx_in.data = 8'($urandom);
        exp_tx.push_back(tx_in.data);
        tx_in.valid = 1'b1;
        send_data = 8'($urandom);
        exp_rx.push_back(send_data);
        send = 1'b1;
        wait_for(RDY, 1'b1, 100);
        check("tx ready", 1, tx_ready);
        cycles(1);
        check("tx ready after take", 0, tx_ready);
        {tx_in.valid, send} = 2'h0;
        cycles(BD * 12);
        check("peer chars left", 0, exp_tx.size() + exp_rx.size());
        hang_up();
        $display("test dial and connect done");
        {answer, retry_en} = 2'h1;
        dial_len = 8'h06;
        timeout = 32'h64;
        expect_str({"atdt", num.substr(0, 1)});
        pulse(dial_req);
        wait_for(FAIL, 1'b1, 2000);
        check("dial fail", 1, fail);
        check("dtr at fail", 0, dtr);
        answer = 1'b1;
        expect_str({"atdt", num.substr(0, 1)});
        wait_for(CONN, 1'b1, 3000);
        check("connected on retry", 1, conn);
        retry_en = 1'b0;
        answer = 1'b0;
        wait_for(CONN, 1'b0, 20);
        check("conn after drop", 0, conn);
        check("dtr after drop", 1, dtr);
        hang_up();
        check("dial chars left", 0, exp_tx.size());
        $display("test timeout and retry done");
        close_out();
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        $display("Error watchdog expected done seen running");
        close_out();
    end
endmodule // tb
